// [hdl/rstsrc_defs.svh]
// Constants of the reset source and status block: offsets, fields,
// reset values and timing.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef RSTSRC_DEFS_SVH
`define RSTSRC_DEFS_SVH

// -----------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------
`define RSTSRC_OFF_CAUSE 12'h000
`define RSTSRC_OFF_STATUS 12'h004

// -----------------------------------------------------------------
// Field positions of the cause register
// -----------------------------------------------------------------
`define RSTSRC_B_TRAP 15
`define RSTSRC_B_BADOP 14
`define RSTSRC_B_SOFT_BROWNOUT_ENABLE 13
`define RSTSRC_B_DSLP 10
`define RSTSRC_B_PROGMEM_SLEEP_POWER 8
`define RSTSRC_B_PIN 7
`define RSTSRC_B_INSTR 6
`define RSTSRC_B_SWDT 5
`define RSTSRC_B_WATCHDOG_TIMEOUT_FLAG 4
`define RSTSRC_B_SLEEP 3
`define RSTSRC_B_IDLE 2
`define RSTSRC_B_BOR 1
`define RSTSRC_B_POR 0

// -----------------------------------------------------------------
// Reset value, implemented bits, config codes
// -----------------------------------------------------------------
`define RSTSRC_CAUSE_RST 16'h0003
`define RSTSRC_CAUSE_MASK 16'hE5FF
`define RSTSRC_BOCFG_OFF 2'h0
`define RSTSRC_BOCFG_SOFT 2'h1
`define RSTSRC_BOCFG_NOSLP 2'h2

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define RSTSRC_CLK_KHZ 25000
`define RSTSRC_PWRT_MS 64

`endif

// [hdl/rstsrc_delay.sv]
// Down counter that times the power-up delay.
// Assumes load is a one-cycle pulse and CYCLES is at least one.
`timescale 1ns/1ps
module rstsrc_delay
#(
  parameter int CNT_W = 21,
  parameter logic [CNT_W-1:0] CYCLES = CNT_W'(1)
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  output logic done
);

  logic [CNT_W-1:0] count_reg;

  // Load gives CYCLES cycles until done
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_reg <= '0;
    else if (load)
      count_reg <= CYCLES - 1'b1;
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end

  assign done = (count_reg == '0) && !load;

endmodule

// [hdl/rstsrc_pkg.sv]
// Types of the reset source and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package rstsrc_pkg;

  // Phases of the system reset sequence
  typedef enum logic [1:0] {
    st_hold,
    st_delay,
    st_run
  } rstsrc_state_t;

endpackage

// [hdl/rstsrc_sync.sv]
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bus coherency is kept.
`timescale 1ns/1ps
module rstsrc_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // Only the second stage is ever read outside
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [hdl/rstsrc_top.sv]
// Reset source merger with cause/power control register on AHB-Lite.
// Assumes CPU, watchdog and power-save pulses run on hclk, and that
// pin and brown-out levels are asynchronous. hresetn is power-on.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "rstsrc_defs.svh"
module rstsrc_top
  import rstsrc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 21,
  parameter int PWRT_CYCLES = `RSTSRC_PWRT_MS * `RSTSRC_CLK_KHZ
)
(
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Asynchronous reset sources
  input wire logic master_clear_pin_n,
  input wire logic brownout_detected,
  input wire logic deep_sleep_brownout,
  // Same-clock reset sources (one-cycle pulses or levels)
  input wire logic instr_reset,
  input wire logic watchdog_reset_source,
  input wire logic trap_conflict,
  input wire logic bad_opcode,
  input wire logic uninit_wreg_reset,
  // Power-save events
  input wire logic power_save_instruction_sleep,
  input wire logic power_save_instruction_idle,
  input wire logic deep_sleep_enable,
  input wire logic sleep_active,
  // Configuration fuses
  input wire logic [1:0] brownout_config_field,
  input wire logic watchdog_fuse_enable,
  input wire logic power_up_timer_enable,
  // Outputs to the system
  output logic system_reset_out,
  output logic brownout_detect_enable,
  output logic watchdog_enable_out,
  output logic progmem_sleep_power
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  localparam logic [CNT_W-1:0] PWRT_LOAD = CNT_W'(PWRT_CYCLES);

  logic [2:0] pins_sync;
  logic pin_rst;
  logic bo_raw;
  logic dsbo;
  logic bo_en;
  logic bo_rst;
  logic any_src;
  logic pwrt_src;
  logic pwrt_load;
  logic pwrt_done;
  rstsrc_state_t state_reg;
  rstsrc_state_t state_next;
  logic pwrt_need_reg;
  logic system_reset_reg;
  logic [15:0] cause_reg;
  logic [15:0] cause_next;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;
  logic [15:0] cause_view;
  logic [ADDR_W-1:0] addr_reg;
  logic wr_reg;
  logic acc_ok;
  logic wr_cause;
  logic [31:0] rd_value;
  logic [31:0] hrdata_reg;

  // Word-aligned match of an address against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // -----------------------------------------------------------------
  // Source conditioning
  // -----------------------------------------------------------------
  rstsrc_sync #(
    .W(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({deep_sleep_brownout, brownout_detected,
               !master_clear_pin_n}),
    .sync_out(pins_sync)
  );

  // Pin and brown-out levels seen only after two flops
  assign pin_rst = pins_sync[0];
  assign bo_raw = pins_sync[1];
  assign dsbo = pins_sync[2];

  // Brown-out enable from the fuse field, the soft bit and sleep_active
  always_comb
  begin
    case (brownout_config_field)
      `RSTSRC_BOCFG_OFF: bo_en = 1'b0;
      `RSTSRC_BOCFG_SOFT: bo_en = cause_reg[`RSTSRC_B_SOFT_BROWNOUT_ENABLE];
      `RSTSRC_BOCFG_NOSLP: bo_en = !sleep_active;
      default: bo_en = 1'b1;
    endcase
  end

  assign bo_rst = bo_raw && bo_en;

  // Every source merged; software flag writes are not in here
  assign any_src = pin_rst || bo_rst || dsbo || instr_reset
                   || watchdog_reset_source || trap_conflict
                   || bad_opcode || uninit_wreg_reset;

  // Sources that call for the power-up delay
  assign pwrt_src = bo_rst || dsbo;

  // -----------------------------------------------------------------
  // System reset sequencing
  // -----------------------------------------------------------------
  // Release waits for quiet sources, then the optional delay
  always_comb
  begin
    state_next = state_reg;
    pwrt_load = 1'b0;
    case (state_reg)
      st_hold:
      begin
        if (!any_src)
        begin
          if (pwrt_need_reg && power_up_timer_enable)
          begin
            state_next = st_delay;
            pwrt_load = 1'b1;
          end
          else
            state_next = st_run;
        end
      end
      st_delay:
      begin
        if (any_src)
          state_next = st_hold; // Any source restarts the timer
        else if (pwrt_done)
          state_next = st_run;
      end
      st_run:
      begin
        if (any_src)
          state_next = st_hold;
      end
      default: state_next = st_hold;
    endcase
  end

  // Power-on lands straight in hold, without the clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= st_hold;
    else
      state_reg <= state_next;
  end

  // Delay owed by power-on or a brown-out until the sequence reaches run
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pwrt_need_reg <= 1'b1;
    else if (pwrt_src)
      pwrt_need_reg <= 1'b1;
    else if (state_next == st_run)
      pwrt_need_reg <= 1'b0;
  end

  rstsrc_delay #(
    .CNT_W(CNT_W),
    .CYCLES(PWRT_LOAD)
  ) u_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(pwrt_load),
    .done(pwrt_done)
  );

  // Registered output: async assert on power-on only; sources assert and release on a clock edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      system_reset_reg <= 1'b1;
    else
      system_reset_reg <= (state_next != st_run);
  end

  assign system_reset_out = system_reset_reg;

  // -----------------------------------------------------------------
  // Cause register events
  // -----------------------------------------------------------------
  // Flags land in the same edge the source is seen, so always
  // at least one cycle before the release
  always_comb
  begin
    hw_set = 16'h0000;
    hw_set[`RSTSRC_B_TRAP] = trap_conflict;
    hw_set[`RSTSRC_B_BADOP] = bad_opcode || uninit_wreg_reset;
    hw_set[`RSTSRC_B_DSLP] = power_save_instruction_sleep
                             && deep_sleep_enable;
    hw_set[`RSTSRC_B_PIN] = pin_rst;
    hw_set[`RSTSRC_B_INSTR] = instr_reset;
    hw_set[`RSTSRC_B_WATCHDOG_TIMEOUT_FLAG] = watchdog_reset_source;
    hw_set[`RSTSRC_B_SLEEP] = power_save_instruction_sleep;
    hw_set[`RSTSRC_B_IDLE] = power_save_instruction_idle;
    hw_set[`RSTSRC_B_BOR] = bo_rst || dsbo;
    hw_set[`RSTSRC_B_POR] = dsbo; // Deep-sleep brown-out re-arms power-on
  end

  // Any power-save instruction drops the time-out flag
  always_comb
  begin
    hw_clr = 16'h0000;
    hw_clr[`RSTSRC_B_WATCHDOG_TIMEOUT_FLAG] = power_save_instruction_sleep
                             || power_save_instruction_idle;
  end

  // Write first, then hardware clear, hardware set last wins
  always_comb
  begin
    cause_next = cause_reg;
    if (wr_cause)
      cause_next = hwdata[15:0] & `RSTSRC_CAUSE_MASK;
    cause_next = cause_next & ~hw_clr;
    cause_next = cause_next | hw_set;
  end

  // Only power-on touches this register; other resets leave it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cause_reg <= `RSTSRC_CAUSE_RST;
    else
      cause_reg <= cause_next;
  end

  // Soft brown-out bit reads zero outside software mode
  always_comb
  begin
    cause_view = cause_next;
    if (brownout_config_field != `RSTSRC_BOCFG_SOFT)
      cause_view[`RSTSRC_B_SOFT_BROWNOUT_ENABLE] = 1'b0;
  end

  // -----------------------------------------------------------------
  // Control outputs
  // -----------------------------------------------------------------
  // Unprogrammed fuse keeps the watchdog running
  assign watchdog_enable_out = watchdog_fuse_enable
                               || cause_reg[`RSTSRC_B_SWDT];
  assign brownout_detect_enable = bo_en;
  assign progmem_sleep_power = cause_reg[`RSTSRC_B_PROGMEM_SLEEP_POWER];

  // -----------------------------------------------------------------
  // AHB-Lite slave
  // -----------------------------------------------------------------
  // Only whole-word transfers are taken; others complete as no-ops
  assign acc_ok = hsel && hready && htrans[1] && (hsize == 3'b010);

  // Address phase captured for the following data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= '0;
      wr_reg <= 1'b0;
    end
    else if (hready)
    begin
      addr_reg <= haddr;
      wr_reg <= acc_ok && hwrite;
    end
  end

  assign wr_cause = wr_reg && hit(addr_reg, ADDR_W'(`RSTSRC_OFF_CAUSE));

  // Cause read value forwarded from next state, so a read right after a
  // write sees the written data; unmapped words read zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (hit(haddr, ADDR_W'(`RSTSRC_OFF_CAUSE)))
      rd_value[15:0] = cause_view;
    else if (hit(haddr, ADDR_W'(`RSTSRC_OFF_STATUS)))
    begin
      rd_value[0] = bo_en;
      rd_value[1] = watchdog_enable_out;
      rd_value[2] = system_reset_reg;
      rd_value[3] = (state_reg == st_delay);
    end
  end

  // Read data registered at the address edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (acc_ok && !hwrite)
      hrdata_reg <= rd_value;
  end

  // Zero wait states, always OKAY
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// [tb/rstsrc_assertions.sv]
// Port checker for the reset source block.
// Assumes one clock, hclk, with hresetn as power-on reset.
`timescale 1ns/1ps
module rstsrc_assertions
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic master_clear_pin_n,
  input wire logic instr_reset,
  input wire logic trap_conflict,
  input wire logic bad_opcode,
  input wire logic uninit_wreg_reset,
  input wire logic [1:0] brownout_config_field,
  input wire logic watchdog_fuse_enable,
  input wire logic power_up_timer_enable,
  input wire logic system_reset_out,
  input wire logic brownout_detect_enable,
  input wire logic watchdog_enable_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_instr; instr_reset |=> system_reset_out; endproperty
  a_instr: assert property (p_instr)
    else $error("instruction reset not seen");
  property p_cpu;
    trap_conflict || bad_opcode || uninit_wreg_reset |=> system_reset_out;
  endproperty
  a_cpu: assert property (p_cpu)
    else $error("cpu fault reset not seen");
  property p_pin; !master_clear_pin_n [*3] |=> system_reset_out; endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset not seen");
  property p_rel;
    $fell(system_reset_out) |-> !$past(instr_reset) && !$past(trap_conflict);
  endproperty
  a_rel: assert property (p_rel)
    else $error("reset dropped with source active");
  property p_por; $rose(hresetn) |-> system_reset_out; endproperty
  a_por: assert property (p_por)
    else $error("reset not held through power-on");
  property p_pwrt;
    $rose(hresetn) && power_up_timer_enable |-> system_reset_out [*8];
  endproperty
  a_pwrt: assert property (p_pwrt)
    else $error("power-up delay cut short");
  property p_wdt; watchdog_fuse_enable |-> watchdog_enable_out; endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog not forced on");
  property p_boff;
    brownout_config_field == 2'h0 |-> !brownout_detect_enable;
  endproperty
  a_boff: assert property (p_boff)
    else $error("brown-out on while fused off");
  property p_bon;
    brownout_config_field == 2'h3 |-> brownout_detect_enable;
  endproperty
  a_bon: assert property (p_bon)
    else $error("brown-out off while fused on");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus)
    else $error("bus not ready or not okay");
endmodule

// [tb/rstsrc_far_model.sv]
// Far-side model: CPU core, watchdog, brown-out detector, power save.
// Assumes fire() is called in the time step of a rising hclk edge.
`timescale 1ns/1ps
module rstsrc_far_model
(
  // Clock
  input wire logic hclk,
  // Source events: 0 instr, 1 wdt, 2 trap, 3 opcode, 4 uninit,
  // 5 sleep, 6 idle, 7 pin low, 8 brown-out, 9 deep-sleep brown-out
  output logic [9:0] ev
);
  // All sources idle; pin is pulled up when released
  initial ev = 10'h000;

  // Holds one source for n cycles, then lets it go
  task automatic fire(input int k, input int n);
    ev[k] <= 1'b1;
    repeat (n) @(posedge hclk);
    ev[k] <= 1'b0;
  endtask
endmodule

// [tb/rstsrc_test.sv]
// Self-checking bench for the reset source block.
// Assumes the far-side model and the port checker are compiled first.
`timescale 1ns/1ps
module rstsrc_test;
  logic hclk, hresetn, hsel, hwrite, dse, slp, wfuse, put;
  logic [11:0] haddr, adr;
  logic [2:0] hsize, hsz;
  logic [1:0] htrans, bcfg;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, sys, bde, wde, pms;
  logic [9:0] ev;
  int n_mismatch = 0;
  int check_count = 0;

  // ------------------------------------------------------------
  // Design, far side and clock
  // ------------------------------------------------------------
  rstsrc_far_model u_far (.hclk(hclk), .ev(ev));
  // Short power-up delay keeps the run brief
  rstsrc_top #(.PWRT_CYCLES(8)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .master_clear_pin_n(~ev[7]), .brownout_detected(ev[8]),
    .deep_sleep_brownout(ev[9]), .instr_reset(ev[0]),
    .watchdog_reset_source(ev[1]), .trap_conflict(ev[2]),
    .bad_opcode(ev[3]), .uninit_wreg_reset(ev[4]),
    .power_save_instruction_sleep(ev[5]),
    .power_save_instruction_idle(ev[6]), .deep_sleep_enable(dse),
    .sleep_active(slp), .brownout_config_field(bcfg),
    .watchdog_fuse_enable(wfuse), .power_up_timer_enable(put),
    .system_reset_out(sys), .brownout_detect_enable(bde),
    .watchdog_enable_out(wde), .progmem_sleep_power(pms));
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // Bus, compare and wait tasks
  // ------------------------------------------------------------
  // Single transfer of size hsz; waits on hready, never on a cycle count
  task automatic bus(input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= adr;
    hsize <= hsz;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic rchk(input logic [31:0] exp);
    bus(1'b0, 32'h0000_0000);
    chk_word(rd, exp);
  endtask
  // Bounded wait for the system reset to drop
  task automatic settle();
    int i;
    repeat (4) @(posedge hclk);
    for (i = 0; i < 40 && sys !== 1'b0; i++) @(posedge hclk);
    chk_bit(sys, 1'b0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rchk(32'h0000_0003);
    bcfg <= 2'h1;
    bus(1'b1, 32'hFFFF_FFFF);
    rchk(32'h0000_E5FF);
    chk_bit(sys, 1'b0);
    chk_bit(bde, 1'b1);
    chk_bit(wde, 1'b1);
    bcfg <= 2'h2;
    rchk(32'h0000_C5FF);
    // Byte-sized write must be dropped by the slave
    hsz = 3'b000;
    bus(1'b1, 32'h0000_0000);
    hsz = 3'b010;
    rchk(32'h0000_C5FF);
    $display("regs done");
  endtask
  task automatic t_sources();
    int k;
    int src[6] = '{0, 1, 2, 3, 4, 7};
    int pos[6] = '{6, 4, 15, 14, 14, 7};
    for (k = 0; k < 6; k++)
    begin
      bus(1'b1, 32'h0000_0100);
      u_far.fire(src[k], k == 5 ? 4 : 1);
      #1 chk_bit(sys, 1'b1);
      settle();
      rchk(32'h0000_0100 | (32'h0000_0001 << pos[k]));
      chk_bit(pms, 1'b1);
    end
    $display("sources done");
  endtask
  task automatic t_psave();
    bus(1'b1, 32'h0000_0000);
    u_far.fire(1, 1);
    settle();
    dse <= 1'b1;
    u_far.fire(5, 1);
    dse <= 1'b0;
    rchk(32'h0000_0408);
    u_far.fire(6, 1);
    rchk(32'h0000_040C);
    $display("power save done");
  endtask
  // Trap lands on the very edge that commits a software clear
  task automatic t_prio();
    bus(1'b1, 32'h0000_0000);
    fork
      bus(1'b1, 32'h0000_0000);
      begin
        repeat (2) @(posedge hclk);
        u_far.fire(2, 1);
      end
    join
    settle();
    rchk(32'h0000_8000);
    bus(1'b1, 32'h0000_0000);
    rchk(32'h0000_0000);
    chk_bit(pms, 1'b0);
    $display("priority done");
  endtask
  task automatic t_cfg();
    slp <= 1'b1;
    #1 chk_bit(bde, 1'b0);
    chk_bit(wde, 1'b0);
    @(posedge hclk);
    bcfg <= 2'h1;
    wfuse <= 1'b1;
    #1 chk_bit(bde, 1'b0);
    chk_bit(wde, 1'b1);
    // Soft enable is clear, so a brown-out must not reset
    @(posedge hclk);
    u_far.fire(8, 3);
    repeat (3) @(posedge hclk);
    chk_bit(sys, 1'b0);
    @(posedge hclk);
    bcfg <= 2'h3;
    slp <= 1'b0;
    u_far.fire(8, 3);
    settle();
    rchk(32'h0000_0002);
    // Mid-run power-on reset brings the register back to its reset value
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    rchk(32'h0000_0003);
    bus(1'b1, 32'h0000_0000);
    u_far.fire(9, 1);
    settle();
    rchk(32'h0000_0003);
    // Status word: brown-out on, watchdog on, reset off, no delay
    adr = 12'h004;
    rchk(32'h0000_0003);
    adr = 12'h000;
    $display("config done");
  endtask

  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    adr = 12'h000;
    hsz = 3'b010;
    hsize = 3'b010;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    dse = 1'b0;
    slp = 1'b0;
    wfuse = 1'b0;
    put = 1'b1;
    bcfg = 2'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    chk_bit(sys, 1'b1);
    settle();
    put <= 1'b0;
    t_regs();
    t_sources();
    t_psave();
    t_prio();
    t_cfg();
    summarize();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    summarize();
  end
endmodule

bind rstsrc_top rstsrc_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp),
  .master_clear_pin_n(master_clear_pin_n), .instr_reset(instr_reset),
  .trap_conflict(trap_conflict), .bad_opcode(bad_opcode),
  .uninit_wreg_reset(uninit_wreg_reset),
  .brownout_config_field(brownout_config_field),
  .watchdog_fuse_enable(watchdog_fuse_enable),
  .power_up_timer_enable(power_up_timer_enable),
  .system_reset_out(system_reset_out),
  .brownout_detect_enable(brownout_detect_enable),
  .watchdog_enable_out(watchdog_enable_out));
